// file: pto_consts.svh
// constants for the prescaled timer block: offsets, fields, reset values
`ifndef PTO_CONSTS_SVH
`define PTO_CONSTS_SVH
// ==========================================================
// register byte addresses
`define PTO_ADDR_COUNT_LOW 12'hfd2
`define PTO_ADDR_COUNT_HIGH 12'hfd3
`define PTO_ADDR_CTRL_A 12'hfd4
`define PTO_ADDR_CTRL_B 12'hfd5
`define PTO_ADDR_EVENT 12'hfd8
// ==========================================================
// field positions
`define PTO_CA_ENABLE 7
`define PTO_CA_OUTSTATE 5
`define PTO_CA_WIDE 4
`define PTO_CB_ASYNC 4
`define PTO_EV_FLAG 0
`define PTO_EV_ENABLE 1
`define PTO_EV_SLEEP 2
// ==========================================================
// reset values and timing
`define PTO_RESET_BYTE 8'h00
`define PTO_CTRL_A_WMASK 8'hdf
`define PTO_INSTR_DIV 2'h3
`define PTO_APB_SLVERR_ON_MISS 1'b1
`endif

// file: pto_pkg.sv
// types shared by the prescaled timer block
package pto_pkg;
    typedef enum logic [2:0] {
        PTO_SRC_PIN,
        PTO_SRC_PIN_INV,
        PTO_SRC_INSTR,
        PTO_SRC_FAST_OSC,
        PTO_SRC_SLOW_OSC,
        PTO_SRC_XTAL_OSC,
        PTO_SRC_RSVD6,
        PTO_SRC_RSVD7
    } pto_src_t;
    typedef enum logic [1:0] {
        PTO_APB_IDLE,
        PTO_APB_ACCESS
    } pto_apb_t;
endpackage

// file: pto_edge_sync.sv
// two-flop synchroniser with rising-edge detect on the second stage
`timescale 1ns/1ps
module pto_edge_sync (
    input wire logic mclk, // system clock
    input wire logic srst, // synchronous reset
    input wire logic din, // level from a foreign source
    output logic level, // synchronised level
    output logic rise // one-cycle pulse on rising edge
);
    import pto_pkg::*;
    typedef struct packed {
        logic stage1;
        logic stage2;
        logic stage3;
    } pto_sync_t;
    pto_sync_t st;
    pto_sync_t next_st;
    always_comb begin
        next_st = st;
        next_st.stage1 = din;
        next_st.stage2 = st.stage1;
        next_st.stage3 = st.stage2;
        if (srst) begin
            next_st = '0;
        end
    end
    always_ff @(posedge mclk) begin
        st <= next_st;
    end
    // first stage only feeds the second
    assign level = st.stage2;
    assign rise = st.stage2 & ~st.stage3;
endmodule // pto_edge_sync

// file: pto_timer.sv
// prescaled 8/16-bit timer with postscaled output, APB register slave
`timescale 1ns/1ps
`include "pto_consts.svh"
module pto_timer (
    input wire logic mclk, // system clock, 250 MHz
    input wire logic srst, // synchronous reset, active high
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [11:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic clkPin, // routed clock pin level
    input wire logic fastOsc, // internal fast oscillator level
    input wire logic slowOsc, // internal slow oscillator level
    input wire logic xtalOsc, // secondary crystal oscillator level
    input wire logic sleepMode, // device is in sleep
    output logic timerOut, // timer output signal
    output logic irqReq, // interrupt request
    output logic wakeReq // wake request out of sleep
);
    import pto_pkg::*;
    // ==========================================================
    // state
    typedef struct packed {
        logic [7:0] countLow;
        logic [7:0] countHigh;
        logic [7:0] highReg;
        logic [7:0] periodBuf;
        logic enable;
        logic wide;
        logic [3:0] postSel;
        logic [2:0] srcSel;
        logic asyncSel;
        logic [3:0] preSel;
        logic [14:0] preCount;
        logic [3:0] postCount;
        logic outLevel;
        logic evFlag;
        logic evEnable;
        logic [1:0] instrDiv;
        logic [31:0] rdata;
        logic ready;
        logic slverr;
        logic irq;
        logic wake;
        pto_apb_t apb;
    } pto_state_t;
    pto_state_t st;
    pto_state_t next_st;
    // ==========================================================
    // helpers
    function automatic logic pre_done(input logic [14:0] cnt,
                                      input logic [3:0] sel);
        logic [14:0] limit;
        limit = 15'((16'h0001 << sel) - 16'h0001);
        pre_done = (cnt == limit);
    endfunction
    function automatic logic [7:0] wbyte(input logic [31:0] d);
        wbyte = d[7:0];
    endfunction
    // ==========================================================
    // source selection and crossing
    logic srcRaw;
    logic srcLevel;
    logic srcRise;
    always_comb begin
        srcRaw = 1'b0;
        case (pto_src_t'(st.srcSel))
            PTO_SRC_PIN: srcRaw = clkPin;
            PTO_SRC_PIN_INV: srcRaw = ~clkPin;
            // phased so its synchronised edge lands on the sampling phase
            PTO_SRC_INSTR: srcRaw = (st.instrDiv == 2'h1);
            PTO_SRC_FAST_OSC: srcRaw = fastOsc;
            PTO_SRC_SLOW_OSC: srcRaw = slowOsc;
            PTO_SRC_XTAL_OSC: srcRaw = xtalOsc;
            default: srcRaw = 1'b0;
        endcase
    end
    // all sources cross into mclk; counting stays in one domain
    pto_edge_sync u_sync (
        .mclk(mclk),
        .srst(srst),
        .din(srcRaw),
        .level(srcLevel),
        .rise(srcRise)
    );
    // ==========================================================
    // next state
    logic setup;
    logic access;
    logic wrLow;
    logic wrHigh;
    logic wrCtrl;
    logic rdLow;
    logic tick;
    logic inTick;
    logic instrPhase;
    logic hit;
    logic [15:0] full;
    always_comb begin
        next_st = st;
        setup = psel & ~penable;
        access = psel & penable & (st.apb == PTO_APB_ACCESS);
        wrLow = access & pwrite & (paddr == `PTO_ADDR_COUNT_LOW);
        wrHigh = access & pwrite & (paddr == `PTO_ADDR_COUNT_HIGH);
        wrCtrl = access & pwrite & ((paddr == `PTO_ADDR_CTRL_A) |
                                    (paddr == `PTO_ADDR_CTRL_B));
        rdLow = access & ~pwrite & (paddr == `PTO_ADDR_COUNT_LOW);
        hit = 1'b0;
        full = {st.countHigh, st.countLow};
        next_st.instrDiv = 2'(st.instrDiv + 2'h1);
        instrPhase = (st.instrDiv == `PTO_INSTR_DIV);
        // sync mode samples edges on the instruction clock only
        if (st.asyncSel) begin
            inTick = srcRise;
        end else begin
            inTick = srcRise & instrPhase & ~sleepMode;
        end
        // async keeps counting through sleep
        tick = 1'b0;
        if (st.enable & inTick) begin
            if (pre_done(st.preCount, st.preSel)) begin
                next_st.preCount = 15'h0000;
                tick = 1'b1;
            end else begin
                next_st.preCount = 15'(st.preCount + 15'h0001);
            end
        end
        if (tick) begin
            if (st.wide) begin
                full = 16'(full + 16'h0001);
                next_st.countLow = full[7:0];
                next_st.countHigh = full[15:8];
                hit = (full == 16'h0000);
            end else if (st.countLow == st.periodBuf) begin
                next_st.countLow = 8'h00;
                next_st.periodBuf = st.highReg;
                hit = 1'b1;
            end else begin
                next_st.countLow = 8'(st.countLow + 8'h01);
            end
        end
        if (hit) begin
            if (st.postCount == st.postSel) begin
                next_st.postCount = 4'h0;
                next_st.outLevel = ~st.outLevel;
                next_st.evFlag = 1'b1;
            end else begin
                next_st.postCount = 4'(st.postCount + 4'h1);
            end
        end
        // ------------------------------------------------------
        // apb slave: one wait-free access phase
        next_st.ready = 1'b0;
        next_st.slverr = 1'b0;
        if (setup) begin
            next_st.apb = PTO_APB_ACCESS;
            next_st.ready = 1'b1;
            next_st.rdata = 32'h00000000;
            if (paddr == `PTO_ADDR_COUNT_LOW) begin
                next_st.rdata[7:0] = st.countLow;
            end else if (paddr == `PTO_ADDR_COUNT_HIGH) begin
                next_st.rdata[7:0] = st.highReg;
            end else if (paddr == `PTO_ADDR_CTRL_A) begin
                next_st.rdata[7:0] = {st.enable, 1'b0, st.outLevel,
                                      st.wide, st.postSel};
            end else if (paddr == `PTO_ADDR_CTRL_B) begin
                next_st.rdata[7:0] = {st.srcSel, st.asyncSel,
                                      st.preSel};
            end else if (paddr == `PTO_ADDR_EVENT) begin
                next_st.rdata[2:0] = {sleepMode, st.evEnable, st.evFlag};
            end else begin
                next_st.slverr = `PTO_APB_SLVERR_ON_MISS;
            end
        end else if (access) begin
            next_st.apb = PTO_APB_IDLE;
        end
        if (rdLow & st.wide) begin
            next_st.highReg = st.countHigh;
        end
        if (wrHigh) begin
            next_st.highReg = wbyte(pwdata);
        end
        if (wrLow) begin
            next_st.countLow = wbyte(pwdata);
            if (st.wide) begin
                next_st.countHigh = st.highReg;
            end
        end
        if (access & pwrite & (paddr == `PTO_ADDR_CTRL_A)) begin
            next_st.enable = pwdata[`PTO_CA_ENABLE];
            next_st.wide = pwdata[`PTO_CA_WIDE];
            next_st.postSel = pwdata[3:0];
        end
        if (access & pwrite & (paddr == `PTO_ADDR_CTRL_B)) begin
            next_st.srcSel = pwdata[7:5];
            next_st.asyncSel = pwdata[`PTO_CB_ASYNC];
            next_st.preSel = pwdata[3:0];
        end
        if (access & pwrite & (paddr == `PTO_ADDR_EVENT)) begin
            next_st.evEnable = pwdata[`PTO_EV_ENABLE];
            // a toggle in the same cycle keeps the flag set
            if (~pwdata[`PTO_EV_FLAG] & ~(hit & (st.postCount ==
                                                st.postSel))) begin
                next_st.evFlag = 1'b0;
            end
        end
        if (wrLow | wrCtrl) begin
            next_st.preCount = 15'h0000;
            next_st.postCount = 4'h0;
        end
        next_st.irq = next_st.evFlag & next_st.evEnable;
        next_st.wake = next_st.evFlag & next_st.evEnable & sleepMode &
                       next_st.asyncSel;
        if (srst) begin
            next_st = '0;
            next_st.apb = PTO_APB_IDLE;
        end
    end
    always_ff @(posedge mclk) begin
        st <= next_st;
    end
    // ==========================================================
    // outputs straight from flops
    assign prdata = st.rdata;
    assign pready = st.ready;
    assign pslverr = st.slverr;
    assign timerOut = st.outLevel;
    assign irqReq = st.irq;
    assign wakeReq = st.wake;
endmodule // pto_timer

// file: pto_timer_monitor.sv
// concurrent checks on the prescaled timer ports
`timescale 1ns/1ps
`include "pto_consts.svh"
module pto_timer_monitor (
    input wire logic mclk, // clock
    input wire logic srst, // reset
    input wire logic psel, // select
    input wire logic penable, // access phase
    input wire logic pwrite, // direction
    input wire logic [11:0] paddr, // address
    input wire logic [31:0] pwdata, // write data
    input wire logic [31:0] prdata, // read data
    input wire logic pready, // ready
    input wire logic pslverr, // error
    input wire logic clkPin, // pin source
    input wire logic fastOsc, // fast source
    input wire logic slowOsc, // slow source
    input wire logic xtalOsc, // crystal source
    input wire logic sleepMode, // sleep
    input wire logic timerOut, // output level
    input wire logic irqReq, // interrupt
    input wire logic wakeReq // wake
);
    logic hit;
    assign hit = paddr inside {`PTO_ADDR_COUNT_LOW, `PTO_ADDR_COUNT_HIGH,
        `PTO_ADDR_CTRL_A, `PTO_ADDR_CTRL_B, `PTO_ADDR_EVENT};
    default clocking dc @(posedge mclk); endclocking
    default disable iff (srst);
    // ====
    // bus answers
    ready_after_setup_a: assert property (
        psel && !penable |=> pready) else $error("no ready after setup");
    ready_in_access_a: assert property (
        pready |-> psel && penable) else $error("ready outside access");
    err_with_ready_a: assert property (
        pslverr |-> pready) else $error("error without ready");
    err_on_miss_a: assert property (
        pready |-> pslverr == !hit) else $error("error flag wrong");
    upper_zero_a: assert property (
        pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    // ====
    // output, flag and wake
    out_state_a: assert property (
        pready && !pwrite && paddr == `PTO_ADDR_CTRL_A
        |-> prdata[5] == timerOut || prdata[5] == $past(timerOut))
        else $error("state bit differs from output");
    // flag and enable only fall through a write
    irq_holds_a: assert property (
        irqReq && !(psel && penable && pwrite)
        && !$past(psel && penable && pwrite) |=> irqReq)
        else $error("interrupt dropped without write");
    wake_needs_irq_a: assert property (
        wakeReq |-> irqReq) else $error("wake without interrupt");
    reset_quiet_a: assert property (
        $fell(srst) |-> !timerOut && !irqReq && !wakeReq && !pready)
        else $error("outputs not cleared by reset");
endmodule // pto_timer_monitor
bind pto_timer pto_timer_monitor i_pto_timer_monitor (.mclk, .srst, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .clkPin,
    .fastOsc, .slowOsc, .xtalOsc, .sleepMode, .timerOut, .irqReq, .wakeReq);

// file: testbench.sv
// self-checking bench for the prescaled timer
`timescale 1ns/1ps
`include "pto_consts.svh"
module testbench;
    logic mclk = 1'b0;
    logic srst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic sleepMode = 1'b0;
    logic [4:0] div = 5'h00;
    logic [31:0] prdata;
    logic pready, pslverr, timerOut, irqReq, wakeReq, rerr;
    logic [7:0] rdat;
    int errTotal = 0;
    int numChecks = 0;
    int cyc = 0;
    int n;
    // sources are divided mclk, so every expected period is exact
    wire clkPin = div[2];
    wire fastOsc = div[1];
    wire xtalOsc = div[3];
    wire slowOsc = div[4];
    pto_timer i_pto_timer (.mclk, .srst, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .clkPin, .fastOsc, .slowOsc,
        .xtalOsc, .sleepMode, .timerOut, .irqReq, .wakeReq);
    always #2 mclk = ~mclk;
    always @(posedge mclk) div <= div + 5'h01;
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            errTotal++;
            tally_and_finish();
        end
    end
    // ====
    // tasks
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", numChecks, errTotal);
        if (errTotal == 0 && numChecks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        numChecks++;
        if (got !== exp) begin
            errTotal++;
            $display("ERROR at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic xfer(input logic [11:0] a, input logic w,
        input logic [7:0] d);
        int k;
        k = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= {24'h0, d};
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && k < 16) begin
            @(posedge mclk);
            k++;
        end
        rdat = prdata[7:0];
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [7:0] e);
        xfer(a, 1'b0, 8'h00);
        chk({rerr, rdat}, {1'b0, e});
    endtask
    task automatic waitTog(output int c);
        logic o;
        o = timerOut;
        c = 0;
        while (timerOut === o && c < 600) begin
            @(posedge mclk);
            c++;
        end
    endtask
    // third toggle interval, after buffers have settled; 0 means silent
    task automatic run(input logic [7:0] cb, input logic [7:0] ca, int e);
        xfer(`PTO_ADDR_CTRL_A, 1'b1, 8'h00);
        xfer(`PTO_ADDR_COUNT_HIGH, 1'b1, 8'h03);
        xfer(`PTO_ADDR_COUNT_LOW, 1'b1, 8'h00);
        xfer(`PTO_ADDR_CTRL_B, 1'b1, cb);
        xfer(`PTO_ADDR_CTRL_A, 1'b1, ca);
        waitTog(n);
        if (e != 0) begin
            waitTog(n);
            waitTog(n);
        end
        chk(n, (e == 0) ? 600 : e);
    endtask
    // ====
    // sequence
    initial begin
        repeat (16) @(posedge mclk);
        srst <= 1'b0;
        @(posedge mclk);
        rd(`PTO_ADDR_COUNT_LOW, 8'h00);
        rd(`PTO_ADDR_COUNT_HIGH, 8'h00);
        rd(`PTO_ADDR_CTRL_A, 8'h00);
        rd(`PTO_ADDR_CTRL_B, 8'h00);
        xfer(12'hfd0, 1'b0, 8'h00);
        chk({rerr, rdat}, 9'h100);
        xfer(`PTO_ADDR_CTRL_B, 1'b1, 8'h5a);
        rd(`PTO_ADDR_CTRL_B, 8'h5a);
        xfer(`PTO_ADDR_CTRL_A, 1'b1, 8'h3f);
        rd(`PTO_ADDR_CTRL_A, 8'h1f);
        xfer(`PTO_ADDR_CTRL_A, 1'b1, 8'h10);
        xfer(`PTO_ADDR_COUNT_HIGH, 1'b1, 8'h12);
        xfer(`PTO_ADDR_COUNT_LOW, 1'b1, 8'h34);
        rd(`PTO_ADDR_COUNT_LOW, 8'h34);
        rd(`PTO_ADDR_COUNT_HIGH, 8'h12);
        xfer(`PTO_ADDR_COUNT_HIGH, 1'b1, 8'hff);
        xfer(`PTO_ADDR_COUNT_LOW, 1'b1, 8'hf0);
        xfer(`PTO_ADDR_CTRL_B, 1'b1, 8'h40);
        xfer(`PTO_ADDR_CTRL_A, 1'b1, 8'h90);
        waitTog(n);
        chk(n < 600, 1'b1);
        xfer(`PTO_ADDR_COUNT_LOW, 1'b0, 8'h00);
        rd(`PTO_ADDR_COUNT_HIGH, 8'h00);
        xfer(`PTO_ADDR_EVENT, 1'b1, 8'h03);
        rd(`PTO_ADDR_EVENT, 8'h03);
        chk(irqReq, 1'b1);
        xfer(`PTO_ADDR_CTRL_A, 1'b1, 8'h00);
        xfer(`PTO_ADDR_EVENT, 1'b1, 8'h02);
        rd(`PTO_ADDR_EVENT, 8'h02);
        chk(irqReq, 1'b0);
        run(8'h40, 8'h80, 16);
        run(8'h40, 8'h81, 32);
        run(8'h40, 8'h8f, 256);
        run(8'h41, 8'h80, 32);
        run(8'h40, 8'h00, 0);
        run(8'h10, 8'h80, 32);
        run(8'h30, 8'h80, 32);
        run(8'h90, 8'h80, 128);
        run(8'hb0, 8'h80, 64);
        run(8'hd0, 8'h80, 0);
        sleepMode <= 1'b1;
        run(8'h40, 8'h80, 0);
        run(8'h70, 8'h80, 16);
        rd(`PTO_ADDR_EVENT, 8'h07);
        chk(wakeReq, 1'b1);
        tally_and_finish();
    end
endmodule // testbench
